// >>> hdl/dac_ctrl_regs.vh
// Register offsets, field positions, reset values and codes of the DAC control block
`ifndef DAC_CTRL_REGS_VH
`define DAC_CTRL_REGS_VH

`define ADDR_W 16
`define OFS_DAC_CODE 16'h0096
`define OFS_CONVERTER_SETUP 16'hF200
`define OFS_OUTPUT_ROUTING 16'hF201
`define OFS_ACTIVE_CODE_LOW 16'hF202
`define OFS_ACTIVE_CODE_HIGH 16'hF203
`define OFS_ACCESS_COUNTER_RESET 16'hF204

`define SETUP_ON_BIT 7
`define SETUP_SRC_HI 4
`define SETUP_SRC_LO 0
`define SETUP_WMASK 8'h9F
`define ROUTING_CAL_BIT 7
`define ROUTING_WMASK 8'h8F
`define CLR_CPU_BIT 7
`define CLR_XFER_BIT 6
`define CODE_LOW_MASK 8'hF0

`define RST_SETUP 8'h00
`define RST_ROUTING 8'h00
`define RST_CODE 12'h000

`define SRC_IMMEDIATE 5'h00
`define SRC_CMP_FIRST 5'h08
`define SRC_TMR_FIRST 5'h0C
`define SRC_PWM_FIRST 5'h10
`define SRC_PWM_LAST 5'h17

`endif

// >>> hdl/code_pair_port.v
// One master's view of the shared low/high code address
`timescale 1ns/1ps
module code_pair_port (
  input wire clk_sys,
  input wire srst,
  input wire access,
  input wire write,
  input wire counter_clear,
  output reg phase_high_reg,
  output wire write_low,
  output wire write_high
);
  // Low byte first, high byte second on each toggle
  assign write_low = access & write & ~phase_high_reg;
  assign write_high = access & write & phase_high_reg;

  always @(posedge clk_sys) begin
    if (srst) begin
      phase_high_reg <= 1'b0;
    end else if (counter_clear) begin
      phase_high_reg <= 1'b0;
    end else if (access) begin
      phase_high_reg <= ~phase_high_reg;
    end
  end
endmodule // code_pair_port

// >>> hdl/dac_update_control.v
// DAC update control: registers, two access counters, trigger select and output routing
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`include "dac_ctrl_regs.vh"

module dac_update_control #(
  parameter CODE_W = 12,
  parameter NUM_CMP = 4,
  parameter NUM_TMR = 4,
  parameter NUM_PWM = 8
) (
  input wire clk_sys,
  input wire srst,
  input wire [15:0] cpu_addr,
  input wire [7:0] cpu_wdata,
  input wire cpu_wr,
  input wire cpu_rd,
  output reg [7:0] cpu_rdata,
  input wire xfer_access,
  input wire xfer_write,
  input wire [7:0] xfer_wdata,
  output reg [7:0] xfer_rdata,
  input wire [NUM_CMP-1:0] cmp_event,
  input wire [NUM_TMR-1:0] tmr_event,
  input wire [NUM_PWM-1:0] pwm_event,
  output reg converter_on,
  output reg [CODE_W-1:0] active_code,
  output reg [3:0] pin_route,
  output reg calibration_route
);
  reg [7:0] setup_reg;
  reg [7:0] routing_reg;
  reg [3:0] code_low_reg;
  reg [7:0] code_high_reg;
  reg [CODE_W-1:0] active_reg;
  reg low_seen_reg;
  reg high_seen_reg;
  wire [4:0] src_sel;
  wire cpu_code_hit;
  wire cpu_code_rd_hit;
  wire cpu_clear;
  wire xfer_clear;
  wire cpu_phase;
  wire xfer_phase;
  wire cpu_wlow;
  wire cpu_whigh;
  wire xfer_wlow;
  wire xfer_whigh;
  wire any_wlow;
  wire any_whigh;
  wire [7:0] wlow_data;
  wire [7:0] whigh_data;
  reg event_hit;
  wire trigger;

  // Source code to selected event pulse; reserved codes never fire
  function sel_event;
    input [4:0] src;
    input [NUM_CMP-1:0] cmp;
    input [NUM_TMR-1:0] tmr;
    input [NUM_PWM-1:0] pwm;
    begin
      sel_event = 1'b0;
      if (src >= `SRC_CMP_FIRST && src < `SRC_TMR_FIRST) begin
        sel_event = cmp[src[1:0]];
      end else if (src >= `SRC_TMR_FIRST && src < `SRC_PWM_FIRST) begin
        sel_event = tmr[src[1:0]];
      end else if (src >= `SRC_PWM_FIRST && src <= `SRC_PWM_LAST) begin
        sel_event = pwm[src[2:0]];
      end
    end
  endfunction

  // Code pair bytes in register layout
  function [7:0] low_byte;
    input [CODE_W-1:0] code;
    begin
      low_byte = {code[3:0], 4'h0};
    end
  endfunction

  function [7:0] high_byte;
    input [CODE_W-1:0] code;
    begin
      high_byte = code[11:4];
    end
  endfunction

  assign src_sel = setup_reg[`SETUP_SRC_HI:`SETUP_SRC_LO];
  assign cpu_code_hit = (cpu_wr | cpu_rd) && (cpu_addr == `OFS_DAC_CODE);
  assign cpu_code_rd_hit = cpu_rd && (cpu_addr == `OFS_DAC_CODE);
  assign cpu_clear = cpu_wr && (cpu_addr == `OFS_ACCESS_COUNTER_RESET) &&
                     cpu_wdata[`CLR_CPU_BIT];
  assign xfer_clear = cpu_wr && (cpu_addr == `OFS_ACCESS_COUNTER_RESET) &&
                      cpu_wdata[`CLR_XFER_BIT];

  code_pair_port u_cpu_port (
    .clk_sys(clk_sys),
    .srst(srst),
    .access(cpu_code_hit),
    .write(cpu_wr),
    .counter_clear(cpu_clear),
    .phase_high_reg(cpu_phase),
    .write_low(cpu_wlow),
    .write_high(cpu_whigh)
  );

  // Separate counter so the two masters never disturb each other's byte order
  code_pair_port u_xfer_port (
    .clk_sys(clk_sys),
    .srst(srst),
    .access(xfer_access),
    .write(xfer_write),
    .counter_clear(xfer_clear),
    .phase_high_reg(xfer_phase),
    .write_low(xfer_wlow),
    .write_high(xfer_whigh)
  );

  // CPU wins if both write the same cycle; software keeps them apart anyway
  assign any_wlow = cpu_wlow | xfer_wlow;
  assign any_whigh = cpu_whigh | xfer_whigh;
  assign wlow_data = cpu_wlow ? cpu_wdata : xfer_wdata;
  assign whigh_data = cpu_whigh ? cpu_wdata : xfer_wdata;

  always @* begin
    if (src_sel == `SRC_IMMEDIATE) begin
      event_hit = any_whigh;
    end else begin
      event_hit = sel_event(src_sel, cmp_event, tmr_event, pwm_event);
    end
  end

  // Immediate mode: high byte lands this cycle, so take it from the bus
  assign trigger = event_hit && low_seen_reg && (high_seen_reg || any_whigh);

  always @(posedge clk_sys) begin
    if (srst) begin
      setup_reg <= `RST_SETUP;
      routing_reg <= `RST_ROUTING;
      code_low_reg <= 4'h0;
      code_high_reg <= 8'h00;
      active_reg <= `RST_CODE;
      low_seen_reg <= 1'b0;
      high_seen_reg <= 1'b0;
    end else begin
      if (cpu_wr && cpu_addr == `OFS_CONVERTER_SETUP) begin
        setup_reg <= cpu_wdata & `SETUP_WMASK;
      end
      if (cpu_wr && cpu_addr == `OFS_OUTPUT_ROUTING) begin
        routing_reg <= cpu_wdata & `ROUTING_WMASK;
      end
      if (any_wlow) begin
        code_low_reg <= wlow_data[7:4];
        low_seen_reg <= 1'b1;
      end
      if (any_whigh) begin
        code_high_reg <= whigh_data;
        high_seen_reg <= 1'b1;
      end
      if (trigger) begin
        active_reg <= {(any_whigh ? whigh_data : code_high_reg), code_low_reg};
      end
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always @(posedge clk_sys) begin
    if (srst) begin
      cpu_rdata <= 8'h00;
      xfer_rdata <= 8'h00;
    end else begin
      cpu_rdata <= 8'h00;
      xfer_rdata <= 8'h00;
      if (cpu_code_rd_hit) begin
        cpu_rdata <= cpu_phase ? code_high_reg : {code_low_reg, 4'h0};
      end else if (cpu_rd) begin
        case (cpu_addr)
          `OFS_CONVERTER_SETUP: cpu_rdata <= setup_reg;
          `OFS_OUTPUT_ROUTING: cpu_rdata <= routing_reg;
          `OFS_ACTIVE_CODE_LOW: cpu_rdata <= low_byte(active_reg);
          `OFS_ACTIVE_CODE_HIGH: cpu_rdata <= high_byte(active_reg);
          default: cpu_rdata <= 8'h00;
        endcase
      end
      if (xfer_access && !xfer_write) begin
        xfer_rdata <= xfer_phase ? code_high_reg : {code_low_reg, 4'h0};
      end
    end
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      converter_on <= 1'b0;
      active_code <= `RST_CODE;
      pin_route <= 4'h0;
      calibration_route <= 1'b0;
    end else begin
      converter_on <= setup_reg[`SETUP_ON_BIT];
      active_code <= active_reg;
      pin_route <= routing_reg[3:0];
      calibration_route <= routing_reg[`ROUTING_CAL_BIT];
    end
  end
endmodule // dac_update_control

// >>> testbench/dac_update_properties.sv
// Port checks for the DAC update control block
`timescale 1ns/1ps
module dac_update_properties #(parameter CODE_W = 12) (
  input wire clk_sys,
  input wire srst,
  input wire [15:0] cpu_addr,
  input wire [7:0] cpu_wdata,
  input wire cpu_wr,
  input wire cpu_rd,
  input wire [7:0] cpu_rdata,
  input wire converter_on,
  input wire [CODE_W-1:0] active_code,
  input wire [3:0] pin_route
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_cfg; cpu_wr && cpu_addr == 16'hF200; endsequence
  sequence s_code; cpu_wr && cpu_addr == 16'h0096; endsequence
  sequence s_clr; cpu_wr && cpu_addr == 16'hF204 && cpu_wdata[7]; endsequence
  // Immediate source, one stray byte, then a clear so the pair starts on the low byte
  sequence s_pair; s_cfg ##0 cpu_wdata[4:0] == 5'h00 ##1 s_code ##1 s_clr ##1 s_code ##1 s_code;
  endsequence
  property p_on; s_cfg |-> ##2 converter_on == $past(cpu_wdata[7], 2); endproperty
  property p_route;
    cpu_wr && cpu_addr == 16'hF201 |-> ##2 pin_route == $past(cpu_wdata[3:0], 2); endproperty
  property p_zero; cpu_rd && cpu_addr[15:1] == 15'h7902 |=> cpu_rdata == 8'h00; endproperty
  property p_idle; !cpu_rd |=> cpu_rdata == 8'h00; endproperty
  property p_lo; cpu_rd && cpu_addr == 16'hF202 |=> cpu_rdata == {active_code[3:0], 4'h0};
  endproperty
  property p_hi; cpu_rd && cpu_addr == 16'hF203 |=> cpu_rdata == active_code[11:4]; endproperty
  property p_imm;
    s_pair |-> ##2 active_code == {$past(cpu_wdata, 2), $past(cpu_wdata[7:4], 3)}; endproperty
  property p_rlow; s_clr ##1 cpu_rd && cpu_addr == 16'h0096 |=> cpu_rdata[3:0] == 4'h0;
  endproperty
  a_on: assert property (p_on) else $error("enable mismatch");
  a_route: assert property (p_route) else $error("route mismatch");
  a_zero: assert property (p_zero) else $error("clear or unmapped read not zero");
  a_idle: assert property (p_idle) else $error("read data without read");
  a_lo: assert property (p_lo) else $error("active low read mismatch");
  a_hi: assert property (p_hi) else $error("active high read mismatch");
  a_imm: assert property (p_imm) else $error("immediate update mismatch");
  a_rlow: assert property (p_rlow) else $error("low byte after clear mismatch");
endmodule // dac_update_properties
bind dac_update_control dac_update_properties #(.CODE_W(CODE_W)) u_props (.*);

// >>> testbench/dac_update_control_tb_top.sv
// Self-checking bench for the DAC update control block
`timescale 1ns/1ps
module dac_update_control_tb_top;
  logic clk_sys = 1'h0, srst = 1'h1, cpu_wr = 1'h0, cpu_rd = 1'h0, xfer_access = 1'h0;
  logic xfer_write = 1'h0;
  logic [7:0] cpu_wdata = 8'h00, xfer_wdata = 8'h00, cpu_rdata, xfer_rdata;
  logic [15:0] cpu_addr = 16'h0000, ev = 16'h0000;
  logic [11:0] active_code;
  logic [3:0] pin_route;
  logic converter_on, calibration_route;
  int err_total = 0, checks_done = 0;
  always #2.5 clk_sys = ~clk_sys;
  dac_update_control u_dut (.*, .cmp_event(ev[3:0]), .tmr_event(ev[7:4]),
    .pwm_event(ev[15:8]));
  task chk(string nm, logic [11:0] seen, logic [11:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // First edge may carry an event pulse; all later edges are idle
  task cyc(int n, logic [15:0] v);
    @(posedge clk_sys);
    cpu_wr <= 1'h0;
    ev <= v;
    repeat (n) @(posedge clk_sys) ev <= 16'h0000;
    #1;
  endtask
  task w(logic [15:0] a, logic [7:0] d);
    @(posedge clk_sys);
    cpu_wr <= 1'h1;
    cpu_addr <= a;
    cpu_wdata <= d;
  endtask
  task r(logic [15:0] a, logic [7:0] e);
    @(posedge clk_sys);
    cpu_wr <= 1'h0;
    cpu_rd <= 1'h1;
    cpu_addr <= a;
    @(posedge clk_sys) cpu_rd <= 1'h0;
    #1 chk("rdata", {4'h0, cpu_rdata}, {4'h0, e});
  endtask
  task x(logic wr, logic [7:0] d);
    @(posedge clk_sys);
    cpu_wr <= 1'h0;
    xfer_access <= 1'h1;
    xfer_write <= wr;
    xfer_wdata <= d;
    @(posedge clk_sys) xfer_access <= 1'h0;
    #1 chk("xfer_rdata", {4'h0, xfer_rdata}, wr ? 12'h000 : {4'h0, d});
  endtask
  task t_regs;
    for (int a = 16'hF200; a < 16'hF206; a++) r(a[15:0], 8'h00);
    w(16'hF201, 8'hFF);
    r(16'hF201, 8'h8F);
    chk("route", {7'h00, calibration_route, pin_route}, 12'h01F);
    $display("done registers");
  endtask
  task t_imm;
    w(16'hF200, 8'h80);
    w(16'h0096, 8'h11);
    w(16'hF204, 8'h80);
    w(16'h0096, 8'h7F);
    w(16'h0096, 8'hC1);
    cyc(2, 16'h0000);
    chk("code", active_code, 12'hC17);
    w(16'hF204, 8'h80);
    r(16'h0096, 8'h70);
    r(16'h0096, 8'hC1);
    r(16'hF202, 8'h70);
    r(16'hF203, 8'hC1);
    $display("done immediate");
  endtask
  task t_xfer;
    w(16'hF200, 8'h88);
    // CPU stays off the pair while the transfer side writes it
    x(1'h1, 8'h50);
    x(1'h1, 8'h9A);
    cyc(3, 16'h0000);
    chk("code", active_code, 12'hC17);
    cyc(2, 16'h0001);
    chk("code", active_code, 12'h9A5);
    x(1'h0, 8'h50);
    w(16'hF204, 8'h40);
    x(1'h0, 8'h50);
    $display("done transfer");
  endtask
  task t_events;
    for (int i = 1; i < 16; i++) begin
      w(16'hF200, 8'h88 + i[7:0]);
      w(16'h0096, {i[3:0], 4'h0});
      w(16'h0096, i[7:0]);
      cyc(2, 16'h0001 << i);
      chk("code", active_code, {i[7:0], i[3:0]});
    end
    w(16'hF200, 8'hFF);
    r(16'hF200, 8'h9F);
    cyc(2, 16'hFFFF);
    chk("code", active_code, 12'h0FF);
    w(16'hF200, 8'h00);
    cyc(2, 16'h0000);
    chk("on", {11'h000, converter_on}, 12'h000);
    $display("done events");
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    srst <= 1'h0;
    t_regs;
    t_imm;
    t_xfer;
    t_events;
    final_report;
  end
endmodule // dac_update_control_tb_top
